/* rtl/sadc_pkg.sv */
// Package: register map, field positions, reset values and timing of the converter control block
// Notes on behaviour
// R1: Selections apply only while converter enabled
// R2: Result right-justified, left-justified when left_adjust set
// R3: Low byte read blocks result updates
// R4: High byte read re-enables result updates
// R5: Done flag rises even when result discarded
// R6: Start bit begins conversion, cleared when done
// R7: Channel change waits until conversion ends; free running never ends one, so the old channel stays
// R8: Auto trigger uses selected trigger source
// R9: Trigger rising edge resets prescaler, starts conversion
// R10: Edges during conversion and held levels ignored
// R11: Trigger flags set regardless; software clears them
// R12: Done-flag trigger restarts on every completion
// R13: Start bit works and reads one always; the code reads it as zero once a conversion has ended and the block is idle
// R14: Differential gain 1x/8x/20x/32x, single-ended bypassed
// R15: Channel all ones selects temperature sensor
// R16: Any of eleven pins selectable single-ended
// R17: Three-bit field chooses converter reference
// R18: Low disable bits gate lower pin inputs
// R19: Bit 3 gates external reference pin input
// R20: High disable bits gate upper pin inputs
// R21: Conversion lasts 13 cycles, first 25
// R22: Completion writes result, sets flag, clears start
// R23: Prescaler runs only while enabled
// R24: Free running restarts immediately, start stays one
// R25: Writing zero to start does nothing
// R26: Disabling aborts conversion and clears start
package sadc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DISABLE_LOW = 6'h01;
  localparam logic [5:0] IDX_DISABLE_HIGH = 6'h02;
  localparam logic [5:0] IDX_CONTROL_B = 6'h03;
  localparam logic [5:0] IDX_CONTROL_A = 6'h04;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h05;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h06;
  localparam logic [5:0] IDX_INPUT_SELECT = 6'h07;
  // converter_control_a fields
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_DONE = 4;
  localparam int CA_PRESC_LSB = 0;
  // converter_control_b fields
  localparam int CB_GAIN_SEL = 7;
  localparam int CB_LEFT_ADJ = 6;
  localparam int CB_REF2 = 4;
  localparam int CB_TSEL_LSB = 0;
  // input_select_register fields
  localparam int IS_REF_LSB = 6;
  localparam int IS_CHAN_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_DISABLE = 8'h00;
  localparam logic [2:0] RST_FIELD3 = 3'h0;
  localparam logic [5:0] RST_CHAN = 6'h00;
  // Channel codes and the done-flag trigger select code
  localparam logic [5:0] CHAN_LAST_SINGLE = 6'h0a;
  localparam logic [5:0] CHAN_TEMP = 6'h3f;
  localparam logic [2:0] TSEL_DONE_FLAG = 3'h0;
  // Conversion length in converter clock cycles
  localparam logic [4:0] NORMAL_CYCLES = 5'd13;
  localparam logic [4:0] FIRST_CYCLES = 5'd25;
endpackage

/* rtl/sadc_ctrl.sv */
// Converter control: APB registers, conversion sequencing, result lock and pin input gating
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module sadc_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources, levels of other blocks' flags
  input wire logic [6:0] trigger_in,
  // Analog core
  input wire logic [9:0] afe_result,
  output logic afe_power,
  output logic afe_converting,
  output logic afe_clock_tick,
  output logic [5:0] afe_channel,
  output logic [2:0] afe_reference,
  output logic [1:0] afe_gain,
  output logic afe_gain_bypass,
  output logic afe_temp_select,
  // Status
  output logic conversion_done_flag,
  // Pin inputs and gated port view
  input wire logic [10:0] pin_in,
  input wire logic external_reference_pin,
  output logic [10:0] pin_read,
  output logic reference_pin_read
);
  typedef enum logic [1:0] {SADC_IDLE, SADC_PEND, SADC_CONV} sadc_phase_t;

  typedef struct packed {
    logic en;
    logic start;
    logic auto_trig;
    logic done;
    logic [2:0] presc_sel;
    logic gain_sel;
    logic left_adj;
    logic ref2;
    logic [2:0] tsel;
    logic [1:0] ref_lo;
    logic [5:0] chan;
    logic [7:0] dis_low;
    logic [7:0] dis_high;
    logic [9:0] result;
    logic locked;
    logic first;
    logic [5:0] app_chan;
    logic [2:0] app_ref;
    logic app_gain_sel;
    sadc_phase_t phase;
    logic [8:0] presc;
    logic [4:0] ticks;
    logic trig_prev;
    logic [31:0] rdata;
    logic [10:0] pin_q;
    logic ref_pin_q;
  } sadc_state_t;

  sadc_state_t st;
  sadc_state_t next_st;

  logic acc;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic mapped;
  logic tick;
  logic free_run;
  logic trig_level;
  logic trig_edge;
  logic complete;
  logic [4:0] conv_len;
  logic [10:0] pin_disable;

  function automatic logic [8:0] presc_limit(input logic [2:0] sel);
    presc_limit = 9'((10'h002 << sel) - 10'h001);
  endfunction

  function automatic logic [15:0] format_result(input logic [9:0] res, input logic left);
    if (left) begin
      format_result = {res, 6'h00};
    end else begin
      format_result = {6'h00, res};
    end
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i >= sadc_pkg::IDX_DISABLE_LOW) && (i <= sadc_pkg::IDX_INPUT_SELECT);
  endfunction

  // Map disable register bits onto analog pins 0..10
  assign pin_disable = {st.dis_high[7:4], st.dis_low[7:4], st.dis_low[2:0]}; // [R18] [R20]

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign idx = paddr[7:2];
  assign mapped = is_mapped(idx) && (paddr[1:0] == 2'b00);
  assign tick = st.en && (st.presc == presc_limit(st.presc_sel));
  assign free_run = st.auto_trig && (st.tsel == sadc_pkg::TSEL_DONE_FLAG); // [R12] [R24]
  assign trig_level = (st.tsel == sadc_pkg::TSEL_DONE_FLAG) ? 1'b0 : trigger_in[st.tsel - 3'h1];
  // Edge only: a level still high at completion starts nothing, and the source's flag
  // is set by its owner whatever its enables; software clears it to re-arm
  assign trig_edge = trig_level & ~st.trig_prev; // [R10] [R11]
  assign conv_len = st.first ? sadc_pkg::FIRST_CYCLES : sadc_pkg::NORMAL_CYCLES; // [R21]
  assign complete = (st.phase == SADC_CONV) && tick && (st.ticks == conv_len - 5'd1);

  // Zero wait states; read data is captured in the setup cycle
  assign pready = acc;
  assign pslverr = acc & ~mapped;
  assign prdata = st.rdata;

  assign afe_power = st.en; // [R1]
  assign afe_converting = (st.phase == SADC_CONV);
  assign afe_clock_tick = tick;
  assign afe_channel = st.app_chan; // [R16]
  assign afe_reference = st.app_ref; // [R17]
  assign afe_gain = {st.app_gain_sel, st.app_chan[0]}; // [R14]
  assign afe_gain_bypass = (st.app_chan <= sadc_pkg::CHAN_LAST_SINGLE) || (st.app_chan == sadc_pkg::CHAN_TEMP);
  assign afe_temp_select = (st.app_chan == sadc_pkg::CHAN_TEMP); // [R15]
  assign conversion_done_flag = st.done;
  assign pin_read = st.pin_q;
  assign reference_pin_read = st.ref_pin_q;

  always_comb begin
    logic [15:0] fmt;
    fmt = format_result(st.result, st.left_adj); // [R2]
    next_st = st;
    // Read data mux, sampled in the setup cycle
    if (psel && !penable) begin
      next_st.rdata = 32'h0000_0000;
      if (paddr[1:0] == 2'b00) begin
        case (idx)
          sadc_pkg::IDX_DISABLE_LOW: next_st.rdata[7:0] = st.dis_low;
          sadc_pkg::IDX_DISABLE_HIGH: next_st.rdata[7:0] = st.dis_high;
          sadc_pkg::IDX_CONTROL_A: next_st.rdata[7:0] = {st.en, st.start, st.auto_trig, st.done, 1'b0, st.presc_sel};
          sadc_pkg::IDX_CONTROL_B: next_st.rdata[7:0] = {st.gain_sel, st.left_adj, 1'b0, st.ref2, 1'b0, st.tsel};
          sadc_pkg::IDX_INPUT_SELECT: next_st.rdata[7:0] = {st.ref_lo, st.chan};
          sadc_pkg::IDX_RESULT_LOW: next_st.rdata[7:0] = fmt[7:0];
          sadc_pkg::IDX_RESULT_HIGH: next_st.rdata[7:0] = fmt[15:8];
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Register writes
    if (wr && mapped) begin
      case (idx)
        sadc_pkg::IDX_DISABLE_LOW: next_st.dis_low = pwdata[7:0];
        sadc_pkg::IDX_DISABLE_HIGH: next_st.dis_high = {pwdata[7:4], 4'h0};
        sadc_pkg::IDX_CONTROL_A: begin
          next_st.en = pwdata[sadc_pkg::CA_ENABLE];
          next_st.auto_trig = pwdata[sadc_pkg::CA_AUTO];
          next_st.presc_sel = pwdata[sadc_pkg::CA_PRESC_LSB +: 3];
          if (pwdata[sadc_pkg::CA_ENABLE] && !st.en) begin
            next_st.first = 1'b1; // [R21]
          end
          if (pwdata[sadc_pkg::CA_DONE]) begin
            next_st.done = 1'b0;
          end
        end
        sadc_pkg::IDX_CONTROL_B: begin
          next_st.gain_sel = pwdata[sadc_pkg::CB_GAIN_SEL];
          next_st.left_adj = pwdata[sadc_pkg::CB_LEFT_ADJ];
          next_st.ref2 = pwdata[sadc_pkg::CB_REF2];
          next_st.tsel = pwdata[sadc_pkg::CB_TSEL_LSB +: 3]; // [R8]
        end
        sadc_pkg::IDX_INPUT_SELECT: begin
          next_st.ref_lo = pwdata[sadc_pkg::IS_REF_LSB +: 2];
          next_st.chan = pwdata[sadc_pkg::IS_CHAN_LSB +: 6];
        end
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // Result byte pair lock
    if (rd && mapped && idx == sadc_pkg::IDX_RESULT_LOW) begin
      next_st.locked = 1'b1; // [R3]
    end
    if (rd && mapped && idx == sadc_pkg::IDX_RESULT_HIGH) begin
      next_st.locked = 1'b0; // [R4]
    end
    // Prescaler: held at zero while disabled, restarts on each converter tick
    if (!next_st.en || tick) begin
      next_st.presc = 9'h000; // [R23]
    end else begin
      next_st.presc = st.presc + 9'h001;
    end
    next_st.trig_prev = trig_level;
    // Sequencing
    case (st.phase)
      SADC_IDLE: begin
        if (st.en && st.auto_trig && !free_run && trig_edge) begin
          next_st.phase = SADC_CONV; // [R9]
          next_st.presc = 9'h000;
          next_st.ticks = 5'd0;
          next_st.start = 1'b1; // [R13]
        end else if (st.en && st.start) begin
          next_st.phase = SADC_PEND; // [R6]
        end
      end
      SADC_PEND: begin
        if (tick) begin
          next_st.phase = SADC_CONV;
          next_st.ticks = 5'd0;
        end
      end
      SADC_CONV: begin
        if (complete) begin
          next_st.done = 1'b1; // [R5] [R22]
          next_st.first = 1'b0;
          next_st.ticks = 5'd0;
          if (!st.locked) begin
            next_st.result = afe_result; // [R3] [R22]
          end
          if (!free_run) begin
            next_st.phase = SADC_IDLE;
            next_st.start = 1'b0; // [R6] [R22]
          end
        end else if (tick) begin
          next_st.ticks = st.ticks + 5'd1;
        end
      end
      default: next_st.phase = SADC_IDLE;
    endcase
    // A written one starts unless the same write clears enable; a written zero is ignored
    if (wr && mapped && idx == sadc_pkg::IDX_CONTROL_A && pwdata[sadc_pkg::CA_START]) begin
      next_st.start = 1'b1; // [R13] [R25]
    end
    // Disable aborts everything
    if (!next_st.en) begin
      next_st.phase = SADC_IDLE; // [R26]
      next_st.start = 1'b0;
      next_st.ticks = 5'd0;
    end
    // Selections track registers only while enabled and not converting
    if (st.en && st.phase != SADC_CONV) begin
      next_st.app_chan = st.chan; // [R1] [R7]
      next_st.app_ref = {st.ref2, st.ref_lo}; // [R17]
      next_st.app_gain_sel = st.gain_sel;
    end
    next_st.pin_q = pin_in & ~pin_disable; // [R18] [R20]
    next_st.ref_pin_q = external_reference_pin & ~st.dis_low[3]; // [R19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.dis_low <= sadc_pkg::RST_DISABLE;
      st.dis_high <= sadc_pkg::RST_DISABLE;
      st.tsel <= sadc_pkg::RST_FIELD3;
      st.chan <= sadc_pkg::RST_CHAN;
      st.phase <= SADC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_START_DURING_CONV: assert property (st.phase == SADC_CONV |-> st.start) // [R6] [R13]
    else $error("start bit low during conversion");
  AST_DISABLE_ABORTS: assert property ($fell(st.en) |-> st.phase == SADC_IDLE && !st.start) // [R26]
    else $error("disable did not abort conversion");
  AST_PRESC_HELD: assert property (!st.en |-> st.presc == 9'h000) // [R23]
    else $error("prescaler running while disabled");
  AST_LOCK_HOLDS: assert property (st.locked && $past(st.locked) |-> $stable(st.result)) // [R3]
    else $error("result changed while locked");
  AST_HIGH_UNLOCKS: assert property (rd && mapped && idx == sadc_pkg::IDX_RESULT_HIGH |=> !st.locked) // [R4]
    else $error("high byte read did not unlock");
  AST_DONE_SET: assert property (complete |=> st.done) // [R5] [R22]
    else $error("done flag not set on completion");
  AST_TRIG_START: assert property (st.phase == SADC_IDLE && st.en && st.auto_trig && !free_run && trig_edge
    ##1 st.en |-> st.phase == SADC_CONV && st.presc == 9'h000 && st.start) // [R9]
    else $error("trigger edge did not start conversion");
  AST_EDGE_IGNORED: assert property (st.phase == SADC_CONV && !tick ##1 st.en
    |-> st.presc == $past(st.presc) + 9'h001) // [R10]
    else $error("prescaler disturbed during conversion");
  AST_CHAN_KEPT: assert property (st.phase == SADC_CONV && $past(st.phase) == SADC_CONV |-> $stable(st.app_chan)) // [R7]
    else $error("channel changed mid conversion");
  AST_FREE_RUN: assert property (complete && free_run ##1 st.en |-> st.phase == SADC_CONV && st.start) // [R24]
    else $error("free running did not restart");
  AST_PIN_GATED: assert property (st.dis_high[4] |=> !pin_read[7]) // [R20]
    else $error("disabled pin input not zero");

  COV_FREE_RUN: cover property (complete && free_run);
  COV_LOST_RESULT: cover property (complete && st.locked);
  COV_TRIGGERED: cover property (st.phase == SADC_IDLE && st.auto_trig && !free_run && trig_edge && st.en);
endmodule

/* testbench/sadc_afe_model.sv */
// Behavioural model of the analog converter core seen by the control block
`timescale 1ns/100ps
module sadc_afe_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core control
  input wire logic afe_power,
  input wire logic afe_converting,
  input wire logic [5:0] afe_channel,
  // Result
  output logic [9:0] afe_result
);
  logic [9:0] idle_pat;
  // Outside a conversion the result is not held, so a late capture shows a wrong value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_pat <= 10'h155;
    end else begin
      idle_pat <= ~idle_pat;
    end
  end
  // Distinct code per channel makes a wrong channel visible in the result
  assign afe_result = (afe_power && afe_converting) ? {afe_channel, 4'h9} : idle_pat;
endmodule

/* testbench/test_sar_adc_conversion_control.sv */
// Register level testbench of the converter control block
`timescale 1ns/100ps
module test_sar_adc_conversion_control;
  localparam logic [5:0] DL = sadc_pkg::IDX_DISABLE_LOW;
  localparam logic [5:0] CB = sadc_pkg::IDX_CONTROL_B;
  localparam logic [5:0] CA = sadc_pkg::IDX_CONTROL_A;
  localparam logic [5:0] RL = sadc_pkg::IDX_RESULT_LOW;
  localparam logic [5:0] RH = sadc_pkg::IDX_RESULT_HIGH;
  localparam logic [5:0] IS = sadc_pkg::IDX_INPUT_SELECT;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] trig;
  logic [9:0] res;
  logic [10:0] pin_in, pin_read;
  logic eref, eref_rd, pw, cv, tk, ts, bp, done;
  logic [5:0] ch;
  logic [2:0] rf;
  logic [1:0] gn;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  sadc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trig), .afe_result(res), .afe_power(pw), .afe_converting(cv), .afe_clock_tick(tk),
    .afe_channel(ch), .afe_reference(rf), .afe_gain(gn), .afe_gain_bypass(bp), .afe_temp_select(ts),
    .conversion_done_flag(done), .pin_in(pin_in), .external_reference_pin(eref), .pin_read(pin_read),
    .reference_pin_read(eref_rd));
  sadc_afe_model i_afe (.pclk(pclk), .presetn(presetn), .afe_power(pw), .afe_converting(cv),
    .afe_channel(ch), .afe_result(res));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic wait_done(output int c);
    c = 0;
    // First look after the edge that ended the last transfer, so a just cleared flag is seen clear
    do begin
      @(negedge pclk);
      c++;
    end while (done !== 1'b1 && c < 200);
    if (c >= 200) begin
      n_errors++;
      end_sim();
    end
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, trig} = '0;
    pin_in = 11'h7ff;
    eref = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, DL, 0);
    check("disable_low reset", q, 32'h0);
    xfer(0, 6'h00, 0);
    check("unmapped error", 32'(err), 32'h1);
    // Input buffer gating
    xfer(1, DL, 32'hf7);
    xfer(1, sadc_pkg::IDX_DISABLE_HIGH, 32'hf0);
    // Port view is registered behind the disable register: one extra cycle
    repeat (2) @(negedge pclk);
    check("pin_read all off", 32'(pin_read), 32'h0);
    check("ref pin open", 32'(eref_rd), 32'h1);
    xfer(1, DL, 32'h08);
    repeat (2) @(negedge pclk);
    check("pin_read upper off", 32'(pin_read), 32'h07f);
    check("ref pin off", 32'(eref_rd), 32'h0);
    // Selection held back while disabled
    xfer(1, IS, 32'h3f);
    @(negedge pclk);
    check("channel disabled", 32'(ch), 32'h0);
    check("power off", 32'(pw), 32'h0);
    // First conversion, temperature channel
    xfer(1, CA, 32'hc0);
    xfer(0, CA, 0);
    check("start reads one", 32'(q[6]), 32'h1);
    check("temp select", 32'(ts), 32'h1);
    wait_done(n);
    check("first length", 32'(n > 40 && n < 60), 32'h1);
    xfer(0, CA, 0);
    check("done, start clear", 32'(q[7:4]), 32'h9);
    xfer(0, RL, 0);
    check("low right", q, 32'hf9);
    xfer(0, RH, 0);
    check("high right", q, 32'h03);
    // Locked result: the discarded conversion uses another channel so a lost lock shows
    xfer(0, RL, 0);
    xfer(1, IS, 32'h05);
    xfer(1, CA, 32'hd0);
    wait_done(n);
    check("normal length", 32'(n > 20 && n < 34), 32'h1);
    check("done while locked", 32'(done), 32'h1);
    // Channel change during the next conversion
    xfer(1, CA, 32'hd0);
    xfer(1, IS, 32'h3f);
    xfer(0, RH, 0);
    check("high kept", q, 32'h03);
    wait_done(n);
    xfer(0, RL, 0);
    check("old channel result", q, 32'h59);
    xfer(0, RH, 0);
    check("high old channel", q, 32'h00);
    check("new channel applied", 32'(ch), 32'h3f);
    // Left adjusted result
    xfer(1, CB, 32'h40);
    xfer(1, CA, 32'hd0);
    wait_done(n);
    xfer(0, RL, 0);
    check("low left", q, 32'h40);
    xfer(0, RH, 0);
    check("high left", q, 32'hfe);
    // Differential gain and reference; selections reach the core one cycle after the register
    xfer(1, CB, 32'h90);
    xfer(1, IS, 32'hcb);
    repeat (2) @(negedge pclk);
    check("gain 32x", 32'({gn, bp}), 32'h6);
    check("reference", 32'(rf), 32'h7);
    // Auto trigger from source 1
    xfer(1, CB, 32'h01);
    xfer(1, CA, 32'hb0);
    @(posedge pclk);
    trig <= 7'h01;
    repeat (3) @(negedge pclk);
    check("trigger starts", 32'(cv), 32'h1);
    xfer(1, CA, 32'ha0);
    xfer(0, CA, 0);
    check("start zero ignored", 32'(cv), 32'h1);
    check("start reads one auto", 32'(q[6]), 32'h1);
    wait_done(n);
    repeat (6) @(negedge pclk);
    check("held level ignored", 32'(cv), 32'h0);
    // Free running restarts on every completion
    xfer(1, CB, 32'h00);
    xfer(1, CA, 32'hf0);
    wait_done(n);
    xfer(1, CA, 32'hb0);
    wait_done(n);
    xfer(0, CA, 0);
    check("free run start", 32'(q[6]), 32'h1);
    // Disable aborts
    xfer(1, CA, 32'h00);
    xfer(0, CA, 0);
    @(negedge pclk);
    check("abort start", 32'({q[6], cv, pw, tk}), 32'h0);
    end_sim();
  end
endmodule
